//--- src/occ_consts.vh
// Constants for the oscillator calibration counter.
`ifndef OCC_CONSTS_VH
`define OCC_CONSTS_VH

// Printed register offsets, each the base plus twice the register's index.
`define OCC_OFS_SELECT_CTRL   32'h5000_1600
`define OCC_OFS_WINDOW_COUNT  32'h5000_1602
`define OCC_OFS_RESULT_LOW    32'h5000_1604
`define OCC_OFS_RESULT_HIGH   32'h5000_1606
`define OCC_OFS_BASE          32'h5000_1600

// Word index inside the slave: (offset - base) / 2, byte address four times that.
`define OCC_IDX_SELECT_CTRL   3'h0
`define OCC_IDX_WINDOW_COUNT  3'h1
`define OCC_IDX_RESULT_LOW    3'h2
`define OCC_IDX_RESULT_HIGH   3'h3

// Field positions.
`define OCC_SEL_LSB           0
`define OCC_SEL_MSB           1
`define OCC_START_BIT         2

// Reset values.
`define OCC_RST_SEL           2'h0
`define OCC_RST_WINDOW        16'h0000
`define OCC_RST_RESULT        32'h0000_0000

// Source select codes.
`define OCC_SRC_SLOW_RC       2'h0
`define OCC_SRC_FAST_RC       2'h1
`define OCC_SRC_SLOW_CRYSTAL  2'h2
`define OCC_SRC_EXTENDED_RC   2'h3

// Synchroniser depth.
`define OCC_SYNC_STAGES       2

`endif

//--- src/occ_sync.v
// Two-flop level synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module occ_sync #(
  parameter WIDTH = 4
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // The first stage feeds the second stage only.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // occ_sync

//--- src/occ_top.v
// Oscillator calibration counter with its AHB-Lite register slave.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "occ_consts.vh"

// How it works
// - Writing one to the start bit begins a measurement and the bit clears itself when the result is valid.
// - The two-bit source field picks slow RC, fast RC, slow crystal or extended RC oscillator in that code order.
// - The sixteen-bit window length is counted down to one on the selected oscillator and sets the window.
// - The low sixteen bits of the fast crystal cycle count over the window read back in the low result register.
// - The high sixteen bits of that same count read back in the high result register.
// - The four registers sit at consecutive locations: select/control, window count, result low, result high.
module occ_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        slow_rc_osc,
  input  wire        fast_rc_osc,
  input  wire        slow_crystal_osc,
  input  wire        extended_rc_osc,
  output wire        calib_busy
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_ARM   = 2'h1;
  localparam ST_COUNT = 2'h2;

  reg  [1:0]  source_sel_r;
  reg         start_r;
  reg  [15:0] window_length_r;
  reg  [31:0] calib_result_r;
  reg  [31:0] fast_cycle_count_r;
  reg  [31:0] fast_cycle_count_nxt;
  reg  [15:0] window_left_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [3:0]  osc_prev_r;
  reg         busy_r;
  reg  [31:0] hrdata_r;
  reg         hreadyout_r;
  reg         hresp_r;
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [2:0]  addr_idx_r;
  reg         addr_ok_r;
  reg         osc_sel;
  reg  [31:0] read_mux;
  wire [3:0]  osc_sync;
  wire [3:0]  osc_edges;
  wire        osc_rise;
  wire        addr_take;
  wire        wr_start;
  wire        window_done;
  wire        sel_hit;
  wire        cnt_hit;

  occ_sync #(
    .WIDTH (4)
  ) u_osc_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({extended_rc_osc, slow_crystal_osc, fast_rc_osc, slow_rc_osc}),
    .sync_out (osc_sync)
  );

  // Every source keeps its own edge history, so a change of source cannot
  // pair the new source with the old one's last level and fake an edge
  // that would open the window part way through a period.
  assign osc_edges = osc_sync & ~osc_prev_r;

  // Oscillator codes map directly onto the edge vector.
  always @* begin
    case (source_sel_r)
      `OCC_SRC_SLOW_RC:      osc_sel = osc_edges[0];
      `OCC_SRC_FAST_RC:      osc_sel = osc_edges[1];
      `OCC_SRC_SLOW_CRYSTAL: osc_sel = osc_edges[2];
      `OCC_SRC_EXTENDED_RC:  osc_sel = osc_edges[3];
      default:               osc_sel = osc_edges[0];
    endcase
  end

  // The edge detector only looks at the second synchroniser stage.
  assign osc_rise = osc_sel;

  // AHB-Lite register slave.
  assign addr_take = hsel & hready & htrans[1];

  // Byte address is four times the index; only the four low words are mapped.
  assign sel_hit = addr_ok_r && (addr_idx_r == `OCC_IDX_SELECT_CTRL);
  assign cnt_hit = addr_ok_r && (addr_idx_r == `OCC_IDX_WINDOW_COUNT);

  assign wr_start = wr_pend_r && sel_hit && hwdata[`OCC_START_BIT];

  always @* begin
    read_mux = 32'h0000_0000;
    if (addr_ok_r) begin
      case (addr_idx_r)
        `OCC_IDX_SELECT_CTRL:  read_mux = {29'h0000_0000, start_r, source_sel_r};
        `OCC_IDX_WINDOW_COUNT: read_mux = {16'h0000, window_length_r};
        `OCC_IDX_RESULT_LOW:   read_mux = {16'h0000, calib_result_r[15:0]};
        `OCC_IDX_RESULT_HIGH:  read_mux = {16'h0000, calib_result_r[31:16]};
        default:               read_mux = 32'h0000_0000;
      endcase
    end
  end

  // Reads insert one wait state so that a write in the previous data phase
  // is already visible; writes complete with no wait.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      addr_idx_r  <= 3'h0;
      addr_ok_r   <= 1'b0;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
      if (rd_pend_r) begin
        hrdata_r    <= read_mux;
        hreadyout_r <= 1'b1;
        rd_pend_r   <= 1'b0;
        wr_pend_r   <= 1'b0;
      end else if (addr_take) begin
        wr_pend_r   <= hwrite;
        rd_pend_r   <= ~hwrite;
        hreadyout_r <= hwrite;
        addr_idx_r  <= haddr[4:2];
        addr_ok_r   <= (haddr[31:5] == 27'h000_0000) && (haddr[4:2] <= `OCC_IDX_RESULT_HIGH);
      end else begin
        wr_pend_r <= 1'b0;
      end
    end
  end

  // Control registers.
  // Source and window writes are dropped while a measurement runs, so the
  // window in flight always matches what software reads back.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_sel_r    <= `OCC_RST_SEL;
      window_length_r <= `OCC_RST_WINDOW;
    end else if (wr_pend_r) begin
      if (sel_hit && !busy_r) begin
        source_sel_r <= hwdata[`OCC_SEL_MSB:`OCC_SEL_LSB];
      end
      if (cnt_hit && !busy_r) begin
        window_length_r <= hwdata[15:0];
      end
    end
  end

  // Measurement engine.
  // A window of length 0 is treated as 1 so the engine cannot hang.
  assign window_done = osc_rise && (window_left_r <= 16'h0001);

  always @* begin
    state_nxt            = state_r;
    fast_cycle_count_nxt = fast_cycle_count_r;
    case (state_r)
      ST_IDLE: begin
        if (wr_start) begin
          state_nxt = ST_ARM;
        end
      end
      ST_ARM: begin
        // The window opens on the first selected edge, so the count
        // spans whole oscillator periods.
        fast_cycle_count_nxt = 32'h0000_0000;
        if (osc_rise) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        fast_cycle_count_nxt = fast_cycle_count_r + 32'h0000_0001;
        if (window_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r            <= ST_IDLE;
      start_r            <= 1'b0;
      busy_r             <= 1'b0;
      osc_prev_r         <= 4'h0;
      window_left_r      <= `OCC_RST_WINDOW;
      fast_cycle_count_r <= `OCC_RST_RESULT;
      calib_result_r     <= `OCC_RST_RESULT;
    end else begin
      state_r            <= state_nxt;
      osc_prev_r         <= osc_sync;
      fast_cycle_count_r <= fast_cycle_count_nxt;
      busy_r             <= (state_nxt != ST_IDLE);
      if (state_r == ST_IDLE && wr_start) begin
        start_r       <= 1'b1;
        window_left_r <= window_length_r;
      end else if (state_r == ST_COUNT && window_done) begin
        start_r        <= 1'b0;
        calib_result_r <= fast_cycle_count_nxt;
      end else if (state_r == ST_COUNT && osc_rise) begin
        window_left_r <= window_left_r - 16'h0001;
      end
    end
  end

  // Outputs come straight from flops, so the bus sees no combinational path.
  assign hrdata     = hrdata_r;
  assign hreadyout  = hreadyout_r;
  assign hresp      = hresp_r;
  assign calib_busy = busy_r;

endmodule // occ_top

//--- verification/occ_assertions.sv
// Concurrent checks on the calibration counter ports.
`timescale 1ns/1ps
module occ_chk (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic        slow_rc_osc,
  input logic        fast_rc_osc,
  input logic        slow_crystal_osc,
  input logic        extended_rc_osc,
  input logic        calib_busy
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire wr = hsel && hready && htrans[1] && hwrite;
  sequence s_start_wr;
    wr && haddr == 32'h0 && !calib_busy ##1 hwdata[2];
  endsequence
  // Busy must not change over the read, or the start bit may legally flip mid-read.
  sequence s_ctrl_rd(b);
    rd && haddr == 32'h0 && calib_busy == b ##1 calib_busy == b ##1 calib_busy == b;
  endsequence
  a_resp_okay: assert property (hresp == 1'h0) else $error("response not okay");
  a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (wr |=> hreadyout) else $error("write stalled");
  a_start_busy: assert property (s_start_wr |=> calib_busy) else $error("start ignored");
  a_window_min: assert property ($rose(calib_busy) |=> calib_busy [*3]) else $error("window short");
  a_unmapped_zero: assert property (rd && haddr > 32'hC |=> ##1 hrdata == 32'h0) else $error("unmapped data");
  a_start_shown: assert property (s_ctrl_rd(1'h1) |-> hrdata[2]) else $error("start bit low");
  a_start_cleared: assert property (s_ctrl_rd(1'h0) |-> hrdata[31:2] == 30'h0) else $error("start bit set");
endmodule // occ_chk
bind occ_top occ_chk u_chk (
  .hclk             (hclk),
  .hresetn          (hresetn),
  .hsel             (hsel),
  .haddr            (haddr),
  .htrans           (htrans),
  .hwrite           (hwrite),
  .hsize            (hsize),
  .hwdata           (hwdata),
  .hready           (hready),
  .hrdata           (hrdata),
  .hreadyout        (hreadyout),
  .hresp            (hresp),
  .slow_rc_osc      (slow_rc_osc),
  .fast_rc_osc      (fast_rc_osc),
  .slow_crystal_osc (slow_crystal_osc),
  .extended_rc_osc  (extended_rc_osc),
  .calib_busy       (calib_busy)
);

//--- verification/oscillator_calibration_counter_tb.sv
// Self-checking bench for the calibration counter.
`timescale 1ns/1ps
`include "occ_consts.vh"
module oscillator_calibration_counter_tb;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, lo;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        slow_rc_osc = 1'h0, fast_rc_osc = 1'h0, slow_crystal_osc = 1'h0, extended_rc_osc = 1'h0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, calib_busy;
  wire         hready = hreadyout;
  int          tick = 0, err_count = 0, checked = 0;
  occ_top u_dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hready),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .slow_rc_osc      (slow_rc_osc),
    .fast_rc_osc      (fast_rc_osc),
    .slow_crystal_osc (slow_crystal_osc),
    .extended_rc_osc  (extended_rc_osc),
    .calib_busy       (calib_busy)
  );
  always #5 hclk = ~hclk;
  // Oscillator periods are 6, 8, 10 and 12 cycles, so each source gives a distinct result.
  always @(posedge hclk) begin
    tick <= tick + 1;
    slow_rc_osc <= (tick / 3) % 2 == 1;
    fast_rc_osc <= (tick / 4) % 2 == 1;
    slow_crystal_osc <= (tick / 5) % 2 == 1;
    extended_rc_osc <= (tick / 6) % 2 == 1;
    if (tick == 80000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk iff hreadyout === 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout === 1'h1);
    r = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    chk(r, e);
  endtask
  task automatic t_regs();
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    rd(32'hC, 32'h0);
    bus(32'h10, 1'h1, 32'h1234);
    rd(32'h10, 32'h0);
    bus(32'h0, 1'h1, 32'hFFF8);
    rd(32'h0, 32'h0);
    bus(32'h8, 1'h1, 32'hFFFF);
    rd(32'h8, 32'h0);
    bus(32'h4, 1'h1, 32'hABCD);
    rd(32'h4, 32'hABCD);
    $display("register test done");
  endtask
  task automatic t_measure(input logic [1:0] src, input logic [15:0] n);
    int c;
    c = n * (6 + 2 * src);
    bus(32'h4, 1'h1, {16'h0, n});
    bus(32'h0, 1'h1, {29'h0, 1'h1, src});
    rd(32'h0, {29'h0, 1'h1, src});
    chk({31'h0, calib_busy}, 32'h1);
    // A window write while busy must not disturb the running measurement.
    bus(32'h4, 1'h1, 32'h1);
    rd(32'h4, {16'h0, n});
    @(posedge hclk iff calib_busy === 1'h0);
    rd(32'h0, {30'h0, src});
    bus(32'h8, 1'h0, 32'h0);
    lo = r;
    bus(32'hC, 1'h0, 32'h0);
    r = {r[15:0], lo[15:0]};
    chk(r, c);
    repeat (20) @(posedge hclk);
    rd(32'h8, lo);
    $display("measure test src %0d done", src);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs();
    for (int s = 0; s < 4; s++) t_measure(2'(s), 16'(s + 1));
    t_measure(`OCC_SRC_SLOW_RC, 16'h2AF8);
    tally_and_finish();
  end
endmodule // oscillator_calibration_counter_tb
